// File: rtl/mtc_pkg.sv
package mtc_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_CTRL_FLAGS  = 8'h88;
  localparam logic [7:0] IDX_MODE_CONFIG = 8'h89;
  localparam logic [7:0] IDX_T0_LOW      = 8'h8a;
  localparam logic [7:0] IDX_T1_LOW      = 8'h8b;
  localparam logic [7:0] IDX_T0_HIGH     = 8'h8c;
  localparam logic [7:0] IDX_T1_HIGH     = 8'h8d;
  localparam logic [7:0] IDX_T2_CTRL     = 8'hc8;
  localparam logic [7:0] IDX_T2_RLD_LOW  = 8'hca;
  localparam logic [7:0] IDX_T2_RLD_HIGH = 8'hcb;
  localparam logic [7:0] IDX_T2_LOW      = 8'hcc;
  localparam logic [7:0] IDX_T2_HIGH     = 8'hcd;

  localparam logic [7:0] RST_BYTE = 8'h00;

  // control/flag bit positions
  localparam int B_TF1 = 7;
  localparam int B_TR1 = 6;
  localparam int B_TF0 = 5;
  localparam int B_TR0 = 4;
  localparam int B_IE1 = 3;
  localparam int B_IT1 = 2;
  localparam int B_IE0 = 1;
  localparam int B_IT0 = 0;

  // mode config bit positions
  localparam int B_CT1    = 6;
  localparam int B_M1_HI  = 5;
  localparam int B_M1_LO  = 4;
  localparam int B_FIRST_TIMER_GATE_ENABLE  = 3;
  localparam int B_CT0    = 2;
  localparam int B_M0_HI  = 1;
  localparam int B_M0_LO  = 0;
  localparam logic [7:0] MODE_WR_MASK = 8'h7f;

  // third timer control bit positions
  localparam int B_THIRD_TIMER_PRESCALE_SELECT   = 7;
  localparam int B_RLD_HI = 4;
  localparam int B_RLD_LO = 3;
  localparam int B_SEL_HI = 1;
  localparam int B_SEL_LO = 0;

  localparam logic [1:0] MODE_13BIT  = 2'b00;
  localparam logic [1:0] MODE_16BIT  = 2'b01;
  localparam logic [1:0] MODE_RELOAD = 2'b10;
  localparam logic [1:0] MODE_SPLIT  = 2'b11;

  localparam logic [1:0] SEL_STOP  = 2'b00;
  localparam logic [1:0] SEL_TIMER = 2'b01;
  localparam logic [1:0] SEL_EVENT = 2'b10;
  localparam logic [1:0] SEL_GATED = 2'b11;

  localparam logic [1:0] RLD_ON_OVF    = 2'b10;
  localparam logic [1:0] RLD_ON_STROBE = 2'b11;

  localparam int PRESCALE_BASE = 12;
  localparam int PRESCALE_LONG = 24;
endpackage

// File: rtl/mtc_timers.sv
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
module mtc_timers #(
  parameter int ADDR_W = 12
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              first_event_input,
  input  wire logic              second_event_input,
  input  wire logic              third_event_input,
  input  wire logic              ext_irq_a_n,
  input  wire logic              ext_irq_b_n,
  input  wire logic              reload_strobe,
  input  wire logic              first_timer_ovf_ack,
  input  wire logic              second_timer_ovf_ack,
  input  wire logic              ext_irq_a_ack,
  input  wire logic              ext_irq_b_ack,
  output logic                   first_timer_overflow_flag,
  output logic                   second_timer_overflow_flag,
  output logic                   ext_irq_a_flag,
  output logic                   ext_irq_b_flag,
  output logic                   second_timer_baud_tick,
  output logic                   third_timer_overflow
);
  function automatic logic fell(input logic older, input logic newer);
    return older & ~newer;
  endfunction

  // {overflow, high, low} after one step of a legacy counter
  function automatic logic [16:0] step(input logic [1:0] m, input logic [7:0] lo,
                                       input logic [7:0] hi, input logic inc);
    logic [12:0] c13;
    logic [16:0] r;
    c13 = 13'h0;
    r   = {1'b0, hi, lo};
    if (inc) begin
      case (m)
        mtc_pkg::MODE_13BIT: begin
          c13 = {hi, lo[4:0]} + 13'h1;
          r   = {&{hi, lo[4:0]}, c13[12:5], lo[7:5], c13[4:0]};
        end
        mtc_pkg::MODE_16BIT: r = {&{hi, lo}, 16'({hi, lo} + 16'h1)};
        mtc_pkg::MODE_RELOAD: begin
          if (&lo) r = {1'b1, hi, hi};
          else r = {1'b0, hi, 8'(lo + 8'h1)};
        end
        default: r = {1'b0, hi, lo};
      endcase
    end
    return r;
  endfunction

  logic [7:0]  ctrl_q, mode_q, tl0_q, th0_q, tl1_q, th1_q, t2c_q;
  logic [15:0] cnt2_q, rld2_q;
  logic [4:0]  pre_q;
  logic [5:0]  s1_q, s2_q;
  logic        pready_q, pslverr_q, baud_q, ovf2_q;
  logic [31:0] prdata_q;
  logic [7:0]  ctrl_d, tl0_d, th0_d, tl1_d, th1_d;
  logic [15:0] cnt2_d;

  // pin samples: 0/1/2 events, 3/4 ext pins, 5 reload strobe
  wire [5:0] pins_w = {reload_strobe, ext_irq_b_n, ext_irq_a_n,
                       third_event_input, second_event_input, first_event_input};
  wire [5:0] fall_w;
  for (genvar i = 0; i < 6; i++) begin : g_edge
    assign fall_w[i] = fell(s2_q[i], s1_q[i]);
  end

  // bus decode
  wire       setup_w   = psel & ~penable;
  wire [7:0] idx_w     = paddr[9:2];
  wire       aligned_w = (paddr[1:0] == 2'b00) & (paddr[ADDR_W-1:10] == '0);
  wire       hit_w     = aligned_w & (idx_w inside {mtc_pkg::IDX_CTRL_FLAGS,
                         mtc_pkg::IDX_MODE_CONFIG, mtc_pkg::IDX_T0_LOW, mtc_pkg::IDX_T1_LOW,
                         mtc_pkg::IDX_T0_HIGH, mtc_pkg::IDX_T1_HIGH, mtc_pkg::IDX_T2_CTRL,
                         mtc_pkg::IDX_T2_RLD_LOW, mtc_pkg::IDX_T2_RLD_HIGH,
                         mtc_pkg::IDX_T2_LOW, mtc_pkg::IDX_T2_HIGH});
  wire       wr_w      = psel & penable & pready_q & pwrite & ~pslverr_q;
  wire [7:0] wd_w      = pwdata[7:0];
  wire       wr_ctrl_w = wr_w & (idx_w == mtc_pkg::IDX_CTRL_FLAGS);
  wire       wr_mode_w = wr_w & (idx_w == mtc_pkg::IDX_MODE_CONFIG);
  wire       wr_tl0_w  = wr_w & (idx_w == mtc_pkg::IDX_T0_LOW);
  wire       wr_th0_w  = wr_w & (idx_w == mtc_pkg::IDX_T0_HIGH);
  wire       wr_tl1_w  = wr_w & (idx_w == mtc_pkg::IDX_T1_LOW);
  wire       wr_th1_w  = wr_w & (idx_w == mtc_pkg::IDX_T1_HIGH);
  wire       wr_t2c_w  = wr_w & (idx_w == mtc_pkg::IDX_T2_CTRL);
  wire       wr_rl_w   = wr_w & (idx_w == mtc_pkg::IDX_T2_RLD_LOW);
  wire       wr_rh_w   = wr_w & (idx_w == mtc_pkg::IDX_T2_RLD_HIGH);
  wire       wr_t2l_w  = wr_w & (idx_w == mtc_pkg::IDX_T2_LOW);
  wire       wr_t2h_w  = wr_w & (idx_w == mtc_pkg::IDX_T2_HIGH);

  logic [7:0] rd_w;
  always_comb begin
    case (idx_w)
      mtc_pkg::IDX_CTRL_FLAGS:  rd_w = ctrl_q;
      mtc_pkg::IDX_MODE_CONFIG: rd_w = mode_q;
      mtc_pkg::IDX_T0_LOW:      rd_w = tl0_q;
      mtc_pkg::IDX_T1_LOW:      rd_w = tl1_q;
      mtc_pkg::IDX_T0_HIGH:     rd_w = th0_q;
      mtc_pkg::IDX_T1_HIGH:     rd_w = th1_q;
      mtc_pkg::IDX_T2_CTRL:     rd_w = t2c_q;
      mtc_pkg::IDX_T2_RLD_LOW:  rd_w = rld2_q[7:0];
      mtc_pkg::IDX_T2_RLD_HIGH: rd_w = rld2_q[15:8];
      mtc_pkg::IDX_T2_LOW:      rd_w = cnt2_q[7:0];
      mtc_pkg::IDX_T2_HIGH:     rd_w = cnt2_q[15:8];
      default:                  rd_w = mtc_pkg::RST_BYTE;
    endcase
  end

  // shared prescaler, 0..23
  localparam int PRE_W = 5;
  localparam logic [PRE_W-1:0] PRE_MID  = PRE_W'(mtc_pkg::PRESCALE_BASE - 1);
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(mtc_pkg::PRESCALE_LONG - 1);
  wire tick12_w = (pre_q == PRE_MID) | (pre_q == PRE_LAST);
  wire tick24_w = (pre_q == PRE_LAST);

  // legacy timer controls
  wire [1:0] m0_w   = mode_q[mtc_pkg::B_M0_HI:mtc_pkg::B_M0_LO];
  wire [1:0] m1_w   = mode_q[mtc_pkg::B_M1_HI:mtc_pkg::B_M1_LO];
  wire       tr0_w  = ctrl_q[mtc_pkg::B_TR0];
  wire       tr1_w  = ctrl_q[mtc_pkg::B_TR1];
  wire       run0_w = tr0_w & (~mode_q[mtc_pkg::B_FIRST_TIMER_GATE_ENABLE] | ext_irq_a_n);
  wire       inc0_w = run0_w & (mode_q[mtc_pkg::B_CT0] ? fall_w[0] : tick12_w);
  wire       inc1_w = tr1_w & (mode_q[mtc_pkg::B_CT1] ? fall_w[1] : tick12_w);
  wire       split_w = (m0_w == mtc_pkg::MODE_SPLIT);

  wire [16:0] st0_w = step(m0_w, tl0_q, th0_q, inc0_w);
  wire [16:0] st1_w = step(m1_w, tl1_q, th1_q, inc1_w); // mode 3 holds
  wire        lo3_ovf_w = split_w & inc0_w & (&tl0_q);
  wire        hi3_inc_w = split_w & tr1_w & tick12_w;
  wire        hi3_ovf_w = hi3_inc_w & (&th0_q);
  wire        ovf0_w    = split_w ? lo3_ovf_w : st0_w[16];
  wire        ovf1_w    = st1_w[16];

  always_comb begin
    if (split_w) begin
      tl0_d = inc0_w ? 8'(tl0_q + 8'h1) : tl0_q;
      th0_d = hi3_inc_w ? 8'(th0_q + 8'h1) : th0_q;
    end else begin
      tl0_d = st0_w[7:0];
      th0_d = st0_w[15:8];
    end
    tl1_d = st1_w[7:0];
    th1_d = st1_w[15:8];
    if (wr_tl0_w) tl0_d = wd_w;
    if (wr_th0_w) th0_d = wd_w;
    if (wr_tl1_w) tl1_d = wd_w;
    if (wr_th1_w) th1_d = wd_w;
  end

  // flags: hardware set wins over ack and over a software write of 0
  wire set_tf0_w = ovf0_w;
  wire set_tf1_w = split_w ? hi3_ovf_w : ovf1_w;
  wire set_ie0_w = ctrl_q[mtc_pkg::B_IT0] ? fall_w[3] : ~ext_irq_a_n;
  wire set_ie1_w = ctrl_q[mtc_pkg::B_IT1] ? fall_w[4] : ~ext_irq_b_n;

  function automatic logic flag_next(input logic cur, input logic set, input logic clr,
                                     input logic wr, input logic wbit);
    return set | (wr ? wbit : (cur & ~clr));
  endfunction

  always_comb begin
    ctrl_d = wr_ctrl_w ? wd_w : ctrl_q;
    ctrl_d[mtc_pkg::B_TF0] = flag_next(ctrl_q[mtc_pkg::B_TF0], set_tf0_w, first_timer_ovf_ack,
                                       wr_ctrl_w, wd_w[mtc_pkg::B_TF0]);
    ctrl_d[mtc_pkg::B_TF1] = flag_next(ctrl_q[mtc_pkg::B_TF1], set_tf1_w, second_timer_ovf_ack,
                                       wr_ctrl_w, wd_w[mtc_pkg::B_TF1]);
    ctrl_d[mtc_pkg::B_IE0] = flag_next(ctrl_q[mtc_pkg::B_IE0], set_ie0_w, ext_irq_a_ack,
                                       wr_ctrl_w, wd_w[mtc_pkg::B_IE0]);
    ctrl_d[mtc_pkg::B_IE1] = flag_next(ctrl_q[mtc_pkg::B_IE1], set_ie1_w, ext_irq_b_ack,
                                       wr_ctrl_w, wd_w[mtc_pkg::B_IE1]);
  end

  // third timer
  wire [1:0] sel2_w = t2c_q[mtc_pkg::B_SEL_HI:mtc_pkg::B_SEL_LO];
  wire [1:0] rld_w  = t2c_q[mtc_pkg::B_RLD_HI:mtc_pkg::B_RLD_LO];
  wire       tick2_w = t2c_q[mtc_pkg::B_THIRD_TIMER_PRESCALE_SELECT] ? tick24_w : tick12_w;
  logic      inc2_w;
  always_comb begin
    case (sel2_w)
      mtc_pkg::SEL_TIMER: inc2_w = tick2_w;
      mtc_pkg::SEL_EVENT: inc2_w = fall_w[2];
      mtc_pkg::SEL_GATED: inc2_w = tick2_w & third_event_input;
      default:            inc2_w = 1'b0;
    endcase
  end
  wire ovf2_w    = inc2_w & (&cnt2_q);
  wire reload2_w = ((rld_w == mtc_pkg::RLD_ON_OVF) & ovf2_w)
                 | ((rld_w == mtc_pkg::RLD_ON_STROBE) & fall_w[5]);

  always_comb begin
    cnt2_d = inc2_w ? 16'(cnt2_q + 16'h1) : cnt2_q;
    if (reload2_w) cnt2_d = rld2_q;
    if (wr_t2l_w) cnt2_d[7:0] = wd_w;
    if (wr_t2h_w) cnt2_d[15:8] = wd_w;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0;
    end else begin
      // zero-wait: ready in the first access cycle
      pready_q  <= setup_w;
      pslverr_q <= setup_w & ~hit_w;
      prdata_q  <= (setup_w & ~pwrite & hit_w) ? {24'h0, rd_w} : 32'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= mtc_pkg::RST_BYTE;
      mode_q <= mtc_pkg::RST_BYTE;
      t2c_q  <= mtc_pkg::RST_BYTE;
      tl0_q  <= mtc_pkg::RST_BYTE;
      th0_q  <= mtc_pkg::RST_BYTE;
      tl1_q  <= mtc_pkg::RST_BYTE;
      th1_q  <= mtc_pkg::RST_BYTE;
      cnt2_q <= 16'h0;
      rld2_q <= 16'h0;
    end else begin
      ctrl_q <= ctrl_d;
      if (wr_mode_w) mode_q <= wd_w & mtc_pkg::MODE_WR_MASK;
      if (wr_t2c_w) t2c_q <= wd_w;
      if (wr_rl_w) rld2_q[7:0] <= wd_w;
      if (wr_rh_w) rld2_q[15:8] <= wd_w;
      tl0_q  <= tl0_d;
      th0_q  <= th0_d;
      tl1_q  <= tl1_d;
      th1_q  <= th1_d;
      cnt2_q <= cnt2_d;
    end
  end

  // pins idle high, so samples reset to one to avoid a false edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q   <= '1;
      s2_q   <= '1;
      pre_q  <= '0;
      baud_q <= 1'b0;
      ovf2_q <= 1'b0;
    end else begin
      s1_q   <= pins_w;
      s2_q   <= s1_q;
      pre_q  <= (pre_q == PRE_LAST) ? '0 : PRE_W'(pre_q + 1'b1);
      baud_q <= ovf1_w; // baud source even when its flag is borrowed
      ovf2_q <= ovf2_w;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign first_timer_overflow_flag  = ctrl_q[mtc_pkg::B_TF0];
  assign second_timer_overflow_flag = ctrl_q[mtc_pkg::B_TF1];
  assign ext_irq_a_flag             = ctrl_q[mtc_pkg::B_IE0];
  assign ext_irq_b_flag             = ctrl_q[mtc_pkg::B_IE1];
  assign second_timer_baud_tick     = baud_q;
  assign third_timer_overflow       = ovf2_q;

  wire t0_wr_w = wr_tl0_w | wr_th0_w;

  property p_tick12;
    @(posedge pclk) disable iff (!presetn)
      tick12_w |=> !tick12_w [*8] ##1 !tick12_w [*3] ##1 tick12_w;
  endproperty
  a_tick12: assert property (p_tick12) else $error("12-cycle tick spacing broken");

  property p_event_count;
    @(posedge pclk) disable iff (!presetn)
      ($fell(s1_q[1]) && tr1_w && mode_q[mtc_pkg::B_CT1] && m1_w == mtc_pkg::MODE_16BIT
       && !wr_tl1_w && !wr_th1_w) |=> ({th1_q, tl1_q} == 16'($past({th1_q, tl1_q}) + 16'h1));
  endproperty
  a_event_count: assert property (p_event_count) else $error("event not counted");

  property p_first_timer_mode_field_upper;
    @(posedge pclk) disable iff (!presetn)
      (m0_w == mtc_pkg::MODE_13BIT && !t0_wr_w) |=> (tl0_q[7:5] == $past(tl0_q[7:5]));
  endproperty
  a_first_timer_mode_field_upper: assert property (p_first_timer_mode_field_upper) else $error("mode 0 upper bits moved");

  property p_reload;
    @(posedge pclk) disable iff (!presetn)
      (m0_w == mtc_pkg::MODE_RELOAD && inc0_w && tl0_q == 8'hff && !t0_wr_w)
        |=> (tl0_q == $past(th0_q)) && first_timer_overflow_flag;
  endproperty
  a_reload: assert property (p_reload) else $error("auto-reload failed");

  property p_stopped;
    @(posedge pclk) disable iff (!presetn)
      (!tr0_w && !split_w && !t0_wr_w) |=> $stable({th0_q, tl0_q});
  endproperty
  a_stopped: assert property (p_stopped) else $error("stopped timer moved");

  property p_second_hold;
    @(posedge pclk) disable iff (!presetn)
      (m1_w == mtc_pkg::MODE_SPLIT && !wr_tl1_w && !wr_th1_w) |=> $stable({th1_q, tl1_q});
  endproperty
  a_second_hold: assert property (p_second_hold) else $error("held timer moved");

  property p_set_wins;
    @(posedge pclk) disable iff (!presetn)
      (set_tf0_w && first_timer_ovf_ack) |=> first_timer_overflow_flag;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("overflow lost to ack");

  property p_ack_clears;
    @(posedge pclk) disable iff (!presetn)
      (ext_irq_b_ack && !set_ie1_w && !wr_ctrl_w) |=> !ext_irq_b_flag;
  endproperty
  a_ack_clears: assert property (p_ack_clears) else $error("ack did not clear");

  property p_t2_event;
    @(posedge pclk) disable iff (!presetn)
      (sel2_w == mtc_pkg::SEL_EVENT && $fell(s1_q[2]) && !reload2_w && !wr_t2l_w
       && !wr_t2h_w) |=> (cnt2_q == 16'($past(cnt2_q) + 16'h1));
  endproperty
  a_t2_event: assert property (p_t2_event) else $error("third event not counted");

  property p_t2_ovf_reload;
    @(posedge pclk) disable iff (!presetn)
      (rld_w == mtc_pkg::RLD_ON_OVF && ovf2_w && !wr_t2l_w && !wr_t2h_w)
        |=> (cnt2_q == $past(rld2_q)) ##0 third_timer_overflow;
  endproperty
  a_t2_ovf_reload: assert property (p_t2_ovf_reload) else $error("reload missed");

  property p_t2_gate;
    @(posedge pclk) disable iff (!presetn)
      (sel2_w == mtc_pkg::SEL_GATED && !third_event_input && !reload2_w && !wr_t2l_w
       && !wr_t2h_w) |=> $stable(cnt2_q);
  endproperty
  a_t2_gate: assert property (p_t2_gate) else $error("gated timer ran");

  property p_apb_ready;
    @(posedge pclk) disable iff (!presetn)
      setup_w |=> pready ##1 !pready || setup_w;
  endproperty
  a_apb_ready: assert property (p_apb_ready) else $error("pready timing wrong");

  c_split: cover property (@(posedge pclk) disable iff (!presetn) hi3_ovf_w);
  c_t2_strobe: cover property (@(posedge pclk) disable iff (!presetn)
                               (rld_w == mtc_pkg::RLD_ON_STROBE) && fall_w[5]);
  c_first_timer_mode_field_ovf: cover property (@(posedge pclk) disable iff (!presetn)
                               (m0_w == mtc_pkg::MODE_13BIT) && ovf0_w);
endmodule // mtc_timers

// File: test/mtc_pin_model.sv
`timescale 1ns/1ps
module mtc_pin_model (
  input  wire logic pclk,
  output logic      first_event_input,
  output logic      second_event_input,
  output logic      third_event_input,
  output logic      ext_irq_a_n,
  output logic      ext_irq_b_n,
  output logic      reload_strobe
);
  // all pins idle high so no stray falling edge follows reset
  initial begin
    first_event_input  = 1'b1;
    second_event_input = 1'b1;
    third_event_input  = 1'b1;
    ext_irq_a_n        = 1'b1;
    ext_irq_b_n        = 1'b1;
    reload_strobe      = 1'b1;
  end

  task automatic drive(input int pin, input logic v);
    case (pin)
      0: first_event_input <= v;
      1: second_event_input <= v;
      2: third_event_input <= v;
      3: ext_irq_a_n <= v;
      4: ext_irq_b_n <= v;
      default: reload_strobe <= v;
    endcase
  endtask

  task automatic level(input int pin, input logic v);
    @(posedge pclk);
    drive(pin, v);
  endtask

  // hold of one gives the fastest legal rate, half the clock
  task automatic pulses(input int pin, input int n, input int hold);
    @(posedge pclk);
    repeat (n) begin
      drive(pin, 1'b0);
      repeat (hold) @(posedge pclk);
      drive(pin, 1'b1);
      repeat (hold) @(posedge pclk);
    end
  endtask
endmodule // mtc_pin_model

// File: test/tb_mtc_timers.sv
`timescale 1ns/1ps
module tb_mtc_timers;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  ack;
  logic        first_event_input, second_event_input, third_event_input;
  logic        ext_irq_a_n, ext_irq_b_n, reload_strobe;
  logic        first_timer_overflow_flag, second_timer_overflow_flag;
  logic        ext_irq_a_flag, ext_irq_b_flag, third_timer_overflow;
  logic [7:0]  rd, a, baud_cnt;
  logic        baud;
  int          fail_count, comparisons, n;

  mtc_timers i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .first_event_input, .second_event_input, .third_event_input,
    .ext_irq_a_n, .ext_irq_b_n, .reload_strobe, .first_timer_ovf_ack(ack[0]),
    .second_timer_ovf_ack(ack[1]), .ext_irq_a_ack(ack[2]), .ext_irq_b_ack(ack[3]),
    .first_timer_overflow_flag, .second_timer_overflow_flag, .ext_irq_a_flag,
    .ext_irq_b_flag, .second_timer_baud_tick(baud), .third_timer_overflow);

  // baud ticks are single-cycle pulses, so count them as they pass
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      baud_cnt <= 8'h00;
    end else if (baud) begin
      baud_cnt <= 8'(baud_cnt + 8'h01);
    end
  end

  mtc_pin_model i_pins (.pclk, .first_event_input, .second_event_input,
    .third_event_input, .ext_irq_a_n, .ext_irq_b_n, .reload_strobe);

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // register index to byte address: four times the index
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
      if (k > 50) begin
        fail_count++;
        final_report();
      end
    end while (pready !== 1'b1);
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // two reads whose sampling edges lie exactly 120 clocks apart
  task automatic rate(input string what, input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    a = rd;
    repeat (117) @(posedge pclk);
    apb(1'b0, idx, 8'h00);
    chk(what, exp, rd - a);
  endtask

  task automatic rchk(input string what, input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(what, exp, rd);
  endtask

  task automatic pulse_ack(input int k);
    @(posedge pclk);
    ack[k] <= 1'b1;
    @(posedge pclk);
    ack[k] <= 1'b0;
    @(posedge pclk);
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    ack = 4'h0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rchk("ctrl", mtc_pkg::IDX_CTRL_FLAGS, 8'h00);
    rchk("mode", mtc_pkg::IDX_MODE_CONFIG, 8'h00);
    apb(1'b0, 8'h80, 8'h00);
    chk("slverr", 8'h01, {7'h0, err});
    apb(1'b1, mtc_pkg::IDX_MODE_CONFIG, 8'hff);
    rchk("mode", mtc_pkg::IDX_MODE_CONFIG, 8'h7f);
    apb(1'b1, mtc_pkg::IDX_MODE_CONFIG, 8'h01);
    apb(1'b1, mtc_pkg::IDX_CTRL_FLAGS, 8'h10);
    rate("t0 timer", mtc_pkg::IDX_T0_LOW, 8'd10);
    apb(1'b1, mtc_pkg::IDX_CTRL_FLAGS, 8'h00);
    rate("t0 stopped", mtc_pkg::IDX_T0_LOW, 8'd0);
    apb(1'b1, mtc_pkg::IDX_MODE_CONFIG, 8'h09);
    apb(1'b1, mtc_pkg::IDX_CTRL_FLAGS, 8'h10);
    i_pins.level(3, 1'b0);
    rate("t0 gated low", mtc_pkg::IDX_T0_LOW, 8'd0);
    i_pins.level(3, 1'b1);
    rate("t0 gated high", mtc_pkg::IDX_T0_LOW, 8'd10);
    apb(1'b1, mtc_pkg::IDX_MODE_CONFIG, 8'h33);
    apb(1'b1, mtc_pkg::IDX_CTRL_FLAGS, 8'h50);
    rate("split high", mtc_pkg::IDX_T0_HIGH, 8'd10);
    rate("t1 held", mtc_pkg::IDX_T1_LOW, 8'd0);
    // counter mode, wrap of the full 16-bit count
    apb(1'b1, mtc_pkg::IDX_MODE_CONFIG, 8'h05);
    apb(1'b1, mtc_pkg::IDX_CTRL_FLAGS, 8'h10);
    apb(1'b1, mtc_pkg::IDX_T0_LOW, 8'hfe);
    apb(1'b1, mtc_pkg::IDX_T0_HIGH, 8'hff);
    i_pins.pulses(0, 2, 1);
    rchk("t0 low", mtc_pkg::IDX_T0_LOW, 8'h00);
    rchk("t0 high", mtc_pkg::IDX_T0_HIGH, 8'h00);
    rchk("ctrl", mtc_pkg::IDX_CTRL_FLAGS, 8'h30);
    pulse_ack(0);
    chk("t0 flag", 8'h00, {7'h0, first_timer_overflow_flag});
    apb(1'b1, mtc_pkg::IDX_MODE_CONFIG, 8'h50);
    apb(1'b1, mtc_pkg::IDX_CTRL_FLAGS, 8'h40);
    apb(1'b1, mtc_pkg::IDX_T1_LOW, 8'hfd);
    apb(1'b1, mtc_pkg::IDX_T1_HIGH, 8'hff);
    i_pins.pulses(1, 3, 2);
    rchk("t1 low", mtc_pkg::IDX_T1_LOW, 8'h00);
    rchk("ctrl", mtc_pkg::IDX_CTRL_FLAGS, 8'hc0);
    chk("baud ticks", 8'd1, baud_cnt);
    pulse_ack(1);
    chk("t1 flag", 8'h00, {7'h0, second_timer_overflow_flag});
    apb(1'b1, mtc_pkg::IDX_MODE_CONFIG, 8'h04);
    apb(1'b1, mtc_pkg::IDX_CTRL_FLAGS, 8'h10);
    apb(1'b1, mtc_pkg::IDX_T0_LOW, 8'hff);
    apb(1'b1, mtc_pkg::IDX_T0_HIGH, 8'h12);
    i_pins.pulses(0, 1, 1);
    rchk("13-bit low", mtc_pkg::IDX_T0_LOW, 8'he0);
    rchk("13-bit high", mtc_pkg::IDX_T0_HIGH, 8'h13);
    apb(1'b1, mtc_pkg::IDX_MODE_CONFIG, 8'h06);
    apb(1'b1, mtc_pkg::IDX_T0_HIGH, 8'h80);
    apb(1'b1, mtc_pkg::IDX_T0_LOW, 8'hff);
    i_pins.pulses(0, 1, 1);
    rchk("reload low", mtc_pkg::IDX_T0_LOW, 8'h80);
    rchk("ctrl", mtc_pkg::IDX_CTRL_FLAGS, 8'h30);
    // third timer: prescaler, stop, gate and event inputs
    apb(1'b1, mtc_pkg::IDX_T2_CTRL, 8'h01);
    rate("t2 by 12", mtc_pkg::IDX_T2_LOW, 8'd10);
    apb(1'b1, mtc_pkg::IDX_T2_CTRL, 8'h81);
    rate("t2 by 24", mtc_pkg::IDX_T2_LOW, 8'd5);
    apb(1'b1, mtc_pkg::IDX_T2_CTRL, 8'h00);
    rate("t2 stopped", mtc_pkg::IDX_T2_LOW, 8'd0);
    apb(1'b1, mtc_pkg::IDX_T2_CTRL, 8'h03);
    i_pins.level(2, 1'b0);
    rate("t2 gate low", mtc_pkg::IDX_T2_LOW, 8'd0);
    i_pins.level(2, 1'b1);
    rate("t2 gate high", mtc_pkg::IDX_T2_LOW, 8'd10);
    apb(1'b1, mtc_pkg::IDX_T2_CTRL, 8'h02);
    apb(1'b0, mtc_pkg::IDX_T2_LOW, 8'h00);
    a = rd;
    i_pins.pulses(2, 4, 1);
    apb(1'b0, mtc_pkg::IDX_T2_LOW, 8'h00);
    chk("t2 events", 8'd4, rd - a);
    apb(1'b1, mtc_pkg::IDX_T2_RLD_LOW, 8'h34);
    apb(1'b1, mtc_pkg::IDX_T2_RLD_HIGH, 8'h12);
    apb(1'b1, mtc_pkg::IDX_T2_LOW, 8'hff);
    apb(1'b1, mtc_pkg::IDX_T2_HIGH, 8'hff);
    apb(1'b1, mtc_pkg::IDX_T2_CTRL, 8'h11);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
      if (n > 40) begin
        fail_count++;
        final_report();
      end
    end while (third_timer_overflow !== 1'b1);
    rchk("t2 reload high", mtc_pkg::IDX_T2_HIGH, 8'h12);
    rchk("t2 reload low", mtc_pkg::IDX_T2_LOW, 8'h34);
    apb(1'b1, mtc_pkg::IDX_T2_CTRL, 8'h18);
    apb(1'b1, mtc_pkg::IDX_T2_LOW, 8'h00);
    apb(1'b1, mtc_pkg::IDX_T2_HIGH, 8'h00);
    i_pins.level(5, 1'b0);
    // the strobe edge needs two samples before the reload lands
    repeat (3) @(posedge pclk);
    rchk("strobe high", mtc_pkg::IDX_T2_HIGH, 8'h12);
    rchk("strobe low", mtc_pkg::IDX_T2_LOW, 8'h34);
    // external flags: edge type on a, level type then edge type on b
    apb(1'b1, mtc_pkg::IDX_CTRL_FLAGS, 8'h01);
    i_pins.pulses(3, 1, 2);
    chk("irq a", 8'h01, {7'h0, ext_irq_a_flag});
    pulse_ack(2);
    chk("irq a", 8'h00, {7'h0, ext_irq_a_flag});
    apb(1'b1, mtc_pkg::IDX_CTRL_FLAGS, 8'h00);
    i_pins.level(4, 1'b0);
    repeat (3) @(posedge pclk);
    chk("irq b", 8'h01, {7'h0, ext_irq_b_flag});
    i_pins.level(4, 1'b1);
    repeat (3) @(posedge pclk);
    pulse_ack(3);
    chk("irq b", 8'h00, {7'h0, ext_irq_b_flag});
    apb(1'b1, mtc_pkg::IDX_CTRL_FLAGS, 8'h04);
    i_pins.pulses(4, 1, 2);
    chk("irq b edge", 8'h01, {7'h0, ext_irq_b_flag});
    final_report();
  end
endmodule // tb_mtc_timers
